/* src/spcw_top.v */
// Serial port configuration and link supervision for a motor drive.
// Assumes an AHB-Lite master, one clock i_mclk at 100 MHz, and a
// frame handler that reports received frames and network writes.
//
// Summary of operation
// R01 - Owner code 02 hands the port to the operator unit, code 03 to the network.
// R02 - Speed code 04, 05, 06 selects 4800, 9600, 19200 bit/s baud divisor.
// R03 - A station address of 1 to 32 is held and only frames to it are accepted.
// R04 - Parity code 00 none, 01 even, 02 odd sets character framing.
// R05 - One or two stop bits are chosen, one by default.
// R06 - A link error acts by code: trip, decel then trip, none, coast, decel.
// R07 - A watchdog of 0.00 to 99.99 s in 10 ms steps flags an error on silence.
// R08 - Reply starts after a wait of 0 to 1000 ms from a complete message.
// R09 - Network writes to the port settings are refused; only local writes apply.
// R10 - At power-up mode 00 restores the default frequency, 01 keeps the stepped one.
// R11 - Clear input code picks the edge that clears a trip and whether it stops a run.
// R12 - The factory debug control resets to disabled and 01 enables it.
// R13 - A watchdog period of zero disables timeout detection.
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spcw_defs.vh"

module spcw_top (
    input wire i_mclk,
    input wire i_resetn,
    input wire i_hsel,
    input wire [11:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    input wire i_frame_done,
    input wire [5:0] i_frame_addr,
    input wire i_net_cfg_write,
    input wire i_fault_clear_input,
    input wire i_running,
    input wire [15:0] i_stepped_freq,
    output reg o_operator_port_owner,
    output reg o_network_port_owner,
    output reg [15:0] o_baud_divisor,
    output reg [1:0] o_parity_select,
    output reg o_two_stop_bits,
    output reg o_frame_accept,
    output reg o_reply_start,
    output reg o_trip,
    output reg [7:0] o_link_fault_trip_code,
    output reg o_decel_stop,
    output reg o_coast_stop,
    output reg o_factory_debug_enable,
    output reg [15:0] o_freq_setpoint,
    output reg o_irq
);

localparam [31:0] WDOG_TICK_CYC = `SPCW_CLK_HZ / 1000 * `SPCW_WDOG_STEP_MS;
localparam [31:0] WAIT_TICK_CYC = `SPCW_CLK_HZ / 1000 * `SPCW_WAIT_STEP_MS;
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_WAIT = 2'h1;

// ---------------------------------------------------------------
// Functions
// ---------------------------------------------------------------
// Baud code to clock divisor, default to slowest rate
function [15:0] baud_div;
    input [2:0] code;
    begin
        case (code)
            `SPCW_BAUD_9600: baud_div = `SPCW_DIV_9600;
            `SPCW_BAUD_19200: baud_div = `SPCW_DIV_19200;
            default: baud_div = `SPCW_DIV_4800;
        endcase
    end
endfunction

// Decoding of a write hit to a given offset
function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
        hit = (addr[11:2] == off[11:2]);
    end
endfunction

// ---------------------------------------------------------------
// Reset release and input synchronisers
// ---------------------------------------------------------------
reg rst_s1, rst_n;
reg [3:0] sync1, sync2;
reg clr_prev, frame_prev;
always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
        rst_s1 <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_s1 <= 1'b1;
        rst_n <= rst_s1;
    end
end

// Two-stage input synchronisers
always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
        sync1 <= 4'h0;
        sync2 <= 4'h0;
        clr_prev <= 1'b0;
        frame_prev <= 1'b0;
    end else begin
        sync1 <= {i_fault_clear_input, i_running, i_frame_done, i_net_cfg_write};
        sync2 <= sync1;
        clr_prev <= sync2[3];
        frame_prev <= sync2[1];
    end
end
wire clr_lvl = sync2[3];
wire running = sync2[2];
wire frame_done = sync2[1] & ~frame_prev; // One accept per held strobe
wire net_write = sync2[0];
wire clr_rise = clr_lvl & ~clr_prev;
wire clr_fall = ~clr_lvl & clr_prev;

// ---------------------------------------------------------------
// Tick generators
// ---------------------------------------------------------------
wire wdog_tick, wait_tick;
spcw_tick_gen #(.PERIOD(WDOG_TICK_CYC)) u_wdog_tick (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .o_tick(wdog_tick)
);
spcw_tick_gen #(.PERIOD(WAIT_TICK_CYC)) u_wait_tick (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .o_tick(wait_tick)
);

// ---------------------------------------------------------------
// AHB-Lite slave
// ---------------------------------------------------------------
reg dp_write, dp_read;
reg [11:0] dp_addr;
wire ap_valid = i_hsel & i_hready & i_htrans[1];
reg [1:0] port_owner_select;
reg [2:0] baud_select;
reg [5:0] station_address;
reg [1:0] parity_select;
reg [1:0] stop_bit_select;
reg [2:0] link_error_action;
reg [13:0] link_watchdog_period;
reg [9:0] reply_wait_time;
reg factory_debug_enable;
reg setpoint_memory_mode;
reg [1:0] fault_clear_mode;
reg [15:0] default_frequency_setting;
reg [3:0] irq_stat, irq_mask;
reg [15:0] retained_freq;
reg timeout_err;
wire [3:0] irq_event;

// Address phase capture; always zero wait states
always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
        dp_write <= 1'b0;
        dp_read <= 1'b0;
        dp_addr <= 12'h000;
        o_hreadyout <= 1'b1;
        o_hresp <= 1'b0;
    end else begin
        dp_write <= ap_valid & i_hwrite;
        dp_read <= ap_valid & ~i_hwrite;
        if (ap_valid) begin
            dp_addr <= i_haddr;
        end
        o_hreadyout <= 1'b1;
        o_hresp <= 1'b0;
    end
end

// Read data registered in the address phase; unmapped reads zero
always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
        o_hrdata <= 32'h00000000;
    end else if (ap_valid & ~i_hwrite) begin
        case (i_haddr[11:2])
            10'h000: o_hrdata <= {30'h0, port_owner_select};
            10'h001: o_hrdata <= {29'h0, baud_select};
            10'h002: o_hrdata <= {26'h0, station_address};
            10'h003: o_hrdata <= {30'h0, parity_select};
            10'h004: o_hrdata <= {30'h0, stop_bit_select};
            10'h005: o_hrdata <= {29'h0, link_error_action};
            10'h006: o_hrdata <= {18'h0, link_watchdog_period};
            10'h007: o_hrdata <= {22'h0, reply_wait_time};
            10'h008: o_hrdata <= {31'h0, factory_debug_enable};
            10'h009: o_hrdata <= {31'h0, setpoint_memory_mode};
            10'h00a: o_hrdata <= {30'h0, fault_clear_mode};
            10'h00b: o_hrdata <= {22'h0, o_link_fault_trip_code, o_trip, timeout_err};
            10'h00c: o_hrdata <= {28'h0, irq_stat};
            10'h00d: o_hrdata <= {28'h0, irq_mask};
            10'h00e: o_hrdata <= {16'h0, default_frequency_setting};
            10'h00f: o_hrdata <= {16'h0, retained_freq};
            default: o_hrdata <= 32'h00000000;
        endcase
    end
end

// Local configuration writes; network writes never reach here [R09]
always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
        port_owner_select <= `SPCW_RST_PORT_OWNER;
        baud_select <= `SPCW_RST_BAUD;
        station_address <= `SPCW_RST_STATION;
        parity_select <= `SPCW_RST_PARITY;
        stop_bit_select <= `SPCW_RST_STOP;
        link_error_action <= `SPCW_RST_ERR_ACTION;
        link_watchdog_period <= `SPCW_RST_WDOG;
        reply_wait_time <= `SPCW_RST_REPLY_WAIT;
        factory_debug_enable <= `SPCW_RST_DEBUG; // [R12]
        setpoint_memory_mode <= `SPCW_RST_SETPT_MODE;
        fault_clear_mode <= `SPCW_RST_CLEAR_MODE;
        default_frequency_setting <= `SPCW_RST_DEFAULT_FREQ;
        irq_mask <= 4'h0;
    end else if (dp_write) begin
        // Illegal codes are ignored, leaving the old setting
        if (hit(dp_addr, `SPCW_OFF_PORT_OWNER) &&
            (i_hwdata[1:0] == `SPCW_OWNER_OPERATOR || i_hwdata[1:0] == `SPCW_OWNER_NETWORK))
            port_owner_select <= i_hwdata[1:0]; // [R01]
        if (hit(dp_addr, `SPCW_OFF_BAUD) &&
            i_hwdata[2:0] >= `SPCW_BAUD_4800 && i_hwdata[2:0] <= `SPCW_BAUD_19200)
            baud_select <= i_hwdata[2:0]; // [R02]
        if (hit(dp_addr, `SPCW_OFF_STATION) && i_hwdata[31:6] == 26'h0 &&
            i_hwdata[5:0] >= `SPCW_STATION_MIN && i_hwdata[5:0] <= `SPCW_STATION_MAX)
            station_address <= i_hwdata[5:0]; // [R03]
        if (hit(dp_addr, `SPCW_OFF_PARITY) && i_hwdata[1:0] <= `SPCW_PAR_ODD)
            parity_select <= i_hwdata[1:0]; // [R04]
        if (hit(dp_addr, `SPCW_OFF_STOP) && (i_hwdata[1:0] == 2'h1 || i_hwdata[1:0] == 2'h2))
            stop_bit_select <= i_hwdata[1:0]; // [R05]
        if (hit(dp_addr, `SPCW_OFF_ERR_ACTION) && i_hwdata[2:0] <= `SPCW_ACT_DECEL)
            link_error_action <= i_hwdata[2:0]; // [R06]
        if (hit(dp_addr, `SPCW_OFF_WDOG) && i_hwdata[13:0] <= `SPCW_WDOG_MAX)
            link_watchdog_period <= i_hwdata[13:0]; // [R07]
        if (hit(dp_addr, `SPCW_OFF_REPLY_WAIT) && i_hwdata[9:0] <= `SPCW_WAIT_MAX)
            reply_wait_time <= i_hwdata[9:0]; // [R08]
        if (hit(dp_addr, `SPCW_OFF_DEBUG))
            factory_debug_enable <= i_hwdata[0]; // [R12]
        if (hit(dp_addr, `SPCW_OFF_SETPT_MODE))
            setpoint_memory_mode <= i_hwdata[0]; // [R10]
        if (hit(dp_addr, `SPCW_OFF_CLEAR_MODE) && i_hwdata[1:0] <= `SPCW_CLR_RISE_RUN)
            fault_clear_mode <= i_hwdata[1:0]; // [R11]
        if (hit(dp_addr, `SPCW_OFF_IRQ_MASK))
            irq_mask <= i_hwdata[3:0];
        if (hit(dp_addr, `SPCW_OFF_DEFAULT_FREQ))
            default_frequency_setting <= i_hwdata[15:0];
    end
end

// ---------------------------------------------------------------
// Port routing and framing outputs
// ---------------------------------------------------------------
always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
        o_operator_port_owner <= 1'b1;
        o_network_port_owner <= 1'b0;
        o_baud_divisor <= 16'h0000;
        o_parity_select <= 2'h0;
        o_two_stop_bits <= 1'b0;
        o_factory_debug_enable <= 1'b0;
    end else begin
        o_operator_port_owner <= (port_owner_select == `SPCW_OWNER_OPERATOR); // [R01]
        o_network_port_owner <= (port_owner_select == `SPCW_OWNER_NETWORK); // [R01]
        o_baud_divisor <= baud_div(baud_select); // [R02]
        o_parity_select <= parity_select; // [R04]
        o_two_stop_bits <= (stop_bit_select == 2'h2); // [R05]
        o_factory_debug_enable <= factory_debug_enable; // [R12]
    end
end

// ---------------------------------------------------------------
// Frame acceptance, watchdog and reply wait
// ---------------------------------------------------------------
wire addr_match = frame_done & (i_frame_addr == station_address) & o_network_port_owner;
reg [13:0] wdog_count;
reg [1:0] state;
reg [9:0] wait_count;

// Watchdog counts 10 ms ticks since last accepted frame
always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
        o_frame_accept <= 1'b0;
        wdog_count <= 14'h0000;
        timeout_err <= 1'b0;
    end else begin
        o_frame_accept <= addr_match; // [R03]
        if (addr_match || link_watchdog_period == 14'h0000) begin // [R13]
            wdog_count <= 14'h0000;
            timeout_err <= 1'b0;
        end else if (wdog_tick && !timeout_err && o_network_port_owner) begin
            if (wdog_count + 14'h0001 >= link_watchdog_period) begin
                timeout_err <= 1'b1; // [R07]
            end
            wdog_count <= wdog_count + 14'h0001;
        end
    end
end

// Reply wait sequencer in 1 ms ticks
always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
        state <= ST_IDLE;
        wait_count <= 10'h000;
        o_reply_start <= 1'b0;
    end else begin
        o_reply_start <= 1'b0;
        case (state)
            ST_IDLE: begin
                if (addr_match) begin
                    if (reply_wait_time == 10'h000) begin
                        o_reply_start <= 1'b1; // [R08]
                    end else begin
                        wait_count <= 10'h000;
                        state <= ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (wait_tick) begin
                    if (wait_count + 10'h001 >= reply_wait_time) begin
                        o_reply_start <= 1'b1; // [R08]
                        state <= ST_IDLE;
                    end
                    wait_count <= wait_count + 10'h001;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

// ---------------------------------------------------------------
// Error action and fault clearing
// ---------------------------------------------------------------
reg timeout_prev;
wire timeout_rise = timeout_err & ~timeout_prev;
wire clr_edge = (fault_clear_mode == `SPCW_CLR_FALL_STOP) ? clr_fall : clr_rise; // [R11]
wire clr_stops = (fault_clear_mode != `SPCW_CLR_RISE_RUN); // [R11]
wire trip_now = timeout_rise && (link_error_action == `SPCW_ACT_TRIP ||
    link_error_action == `SPCW_ACT_DECEL_TRIP);
wire clear_now = clr_edge & o_trip;

always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
        timeout_prev <= 1'b0;
        o_trip <= 1'b0;
        o_link_fault_trip_code <= 8'h00;
        o_decel_stop <= 1'b0;
        o_coast_stop <= 1'b0;
    end else begin
        timeout_prev <= timeout_err;
        if (trip_now) begin
            o_trip <= 1'b1; // [R06]
            o_link_fault_trip_code <= `SPCW_LINK_FAULT_CODE;
        end else if (clear_now) begin
            o_trip <= 1'b0; // [R11]
            o_link_fault_trip_code <= 8'h00;
        end
        if (timeout_rise) begin
            o_decel_stop <= (link_error_action == `SPCW_ACT_DECEL_TRIP ||
                link_error_action == `SPCW_ACT_DECEL); // [R06]
            o_coast_stop <= (link_error_action == `SPCW_ACT_COAST) ||
                (link_error_action == `SPCW_ACT_TRIP); // [R06]
        end else if (clr_edge && clr_stops && running) begin
            o_coast_stop <= 1'b1; // [R11]
        end else if (clr_edge || !timeout_err) begin
            o_decel_stop <= 1'b0;
            o_coast_stop <= 1'b0;
        end
    end
end

// ---------------------------------------------------------------
// Setpoint memory at power-up
// ---------------------------------------------------------------
always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
        retained_freq <= 16'h0000;
        o_freq_setpoint <= 16'h0000;
    end else begin
        retained_freq <= i_stepped_freq;
        o_freq_setpoint <= setpoint_memory_mode ? retained_freq
                                                : default_frequency_setting; // [R10]
    end
end

// ---------------------------------------------------------------
// Interrupts: sticky, write one to clear, set wins
// ---------------------------------------------------------------
assign irq_event = {net_write, clear_now, trip_now, timeout_rise}; // [R09]
always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
        irq_stat <= 4'h0;
        o_irq <= 1'b0;
    end else begin
        if (dp_write && hit(dp_addr, `SPCW_OFF_IRQ_STAT)) begin
            irq_stat <= (irq_stat & ~i_hwdata[3:0]) | irq_event;
        end else begin
            irq_stat <= irq_stat | irq_event;
        end
        o_irq <= |(irq_stat & irq_mask);
    end
end

endmodule

`default_nettype wire

/* pkg/spcw_defs.vh */
// Constants for the serial port configuration and watchdog block.
// Assumes inclusion by bare name from the design files.
`ifndef SPCW_DEFS_VH
`define SPCW_DEFS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SPCW_OFF_PORT_OWNER 12'h000
`define SPCW_OFF_BAUD 12'h004
`define SPCW_OFF_STATION 12'h008
`define SPCW_OFF_PARITY 12'h00c
`define SPCW_OFF_STOP 12'h010
`define SPCW_OFF_ERR_ACTION 12'h014
`define SPCW_OFF_WDOG 12'h018
`define SPCW_OFF_REPLY_WAIT 12'h01c
`define SPCW_OFF_DEBUG 12'h020
`define SPCW_OFF_SETPT_MODE 12'h024
`define SPCW_OFF_CLEAR_MODE 12'h028
`define SPCW_OFF_IRQ_STAT 12'h030
`define SPCW_OFF_IRQ_MASK 12'h034
`define SPCW_OFF_DEFAULT_FREQ 12'h038

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SPCW_RST_PORT_OWNER 2'h2
`define SPCW_RST_BAUD 3'h6
`define SPCW_RST_STATION 6'h01
`define SPCW_RST_PARITY 2'h0
`define SPCW_RST_STOP 2'h1
`define SPCW_RST_ERR_ACTION 3'h2
`define SPCW_RST_WDOG 14'h0000
`define SPCW_RST_REPLY_WAIT 10'h000
`define SPCW_RST_DEBUG 1'h0
`define SPCW_RST_SETPT_MODE 1'h0
`define SPCW_RST_CLEAR_MODE 2'h0
`define SPCW_RST_DEFAULT_FREQ 16'h0000

// ---------------------------------------------------------------
// Codes
// ---------------------------------------------------------------
`define SPCW_OWNER_OPERATOR 2'h2
`define SPCW_OWNER_NETWORK 2'h3
`define SPCW_BAUD_4800 3'h4
`define SPCW_BAUD_9600 3'h5
`define SPCW_BAUD_19200 3'h6
`define SPCW_PAR_ODD 2'h2
`define SPCW_ACT_TRIP 3'h0
`define SPCW_ACT_DECEL_TRIP 3'h1
`define SPCW_ACT_COAST 3'h3
`define SPCW_ACT_DECEL 3'h4
`define SPCW_CLR_FALL_STOP 2'h1
`define SPCW_CLR_RISE_RUN 2'h2
`define SPCW_STATION_MIN 6'h01
`define SPCW_STATION_MAX 6'h20
`define SPCW_WDOG_MAX 14'h270f
`define SPCW_WAIT_MAX 10'h3e8
`define SPCW_LINK_FAULT_CODE 8'h3c

// ---------------------------------------------------------------
// Timing: clock 100 MHz, watchdog step 10 ms, wait step 1 ms
// ---------------------------------------------------------------
`define SPCW_CLK_HZ 100000000
`define SPCW_WDOG_STEP_MS 10
`define SPCW_WAIT_STEP_MS 1
`define SPCW_DIV_4800 16'h5161
`define SPCW_DIV_9600 16'h28b0
`define SPCW_DIV_19200 16'h1458

`endif

/* src/spcw_tick_gen.v */
// Tick divider: one-cycle pulse every PERIOD clocks.
// Assumes an active-low reset from the top, asserted asynchronously and released in step with i_mclk.
`timescale 1ns/1ps
`default_nettype none

module spcw_tick_gen #(
    parameter [31:0] PERIOD = 32'd1000000
) (
    input wire i_mclk,
    input wire i_rst_n,
    output reg o_tick
);

reg [31:0] count;

// ---------------------------------------------------------------
// Free running divider
// ---------------------------------------------------------------
always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        count <= 32'h00000000;
        o_tick <= 1'b0;
    end else if (count == PERIOD - 32'd1) begin
        count <= 32'h00000000;
        o_tick <= 1'b1;
    end else begin
        count <= count + 32'd1;
        o_tick <= 1'b0;
    end
end

endmodule

`default_nettype wire

/* tb/spcw_top_properties.sv */
// Checker for the port configuration block, bound to spcw_top.
// Assumes one clock i_mclk and active-low reset i_resetn.
`timescale 1ns/1ps
`default_nettype none
module spcw_top_properties (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_frame_done,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic o_operator_port_owner,
    input wire logic o_network_port_owner,
    input wire logic [15:0] o_baud_divisor,
    input wire logic [1:0] o_parity_select,
    input wire logic o_frame_accept,
    input wire logic o_reply_start,
    input wire logic o_trip,
    input wire logic [7:0] o_link_fault_trip_code
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    // -----------------------------------------
    // Properties
    // -----------------------------------------
    property p_owner;
        !(o_operator_port_owner && o_network_port_owner);
    endproperty
    a_owner: assert property (p_owner) else $error("both owners");
    property p_baud;
        $changed(o_baud_divisor) && o_baud_divisor != 16'h0000
            |-> o_baud_divisor inside {16'd20833, 16'd10416, 16'd5208};
    endproperty
    a_baud: assert property (p_baud) else $error("bad divisor");
    property p_par;
        o_parity_select != 2'h3;
    endproperty
    a_par: assert property (p_par) else $error("bad parity");
    property p_acc_own;
        o_frame_accept |-> o_network_port_owner;
    endproperty
    a_acc_own: assert property (p_acc_own) else $error("accept off net");
    property p_acc_cause;
        $rose(o_frame_accept) |-> $past(i_frame_done, 3) || $past(i_frame_done, 4);
    endproperty
    a_acc_cause: assert property (p_acc_cause) else $error("accept no frame");
    property p_acc_pulse;
        o_frame_accept |=> !o_frame_accept;
    endproperty
    a_acc_pulse: assert property (p_acc_pulse) else $error("accept long");
    property p_reply_pulse;
        o_reply_start |=> !o_reply_start;
    endproperty
    a_reply_pulse: assert property (p_reply_pulse) else $error("reply long");
    property p_code;
        o_link_fault_trip_code != 8'h00 |-> o_trip && o_link_fault_trip_code == 8'h3c;
    endproperty
    a_code: assert property (p_code) else $error("bad trip code");
    property p_bus;
        o_hreadyout && !o_hresp;
    endproperty
    a_bus: assert property (p_bus) else $error("bus not okay");
    c_acc: cover property (o_frame_accept);
    c_reply: cover property (o_reply_start);
    c_net: cover property ($rose(o_network_port_owner));
endmodule
bind spcw_top spcw_top_properties chk (.*);
`default_nettype wire

/* tb/spcw_net_master.sv */
// Model of the network side frame handler.
// Assumes its tasks are called right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module spcw_net_master (
    input wire logic i_mclk,
    output logic o_frame_done = 1'b0,
    output logic [5:0] o_frame_addr = 6'h3f,
    output logic o_cfg_write = 1'b0
);
    // Frame strobe, address held past the sync delay
    task send_frame(input logic [5:0] a);
        begin
            o_frame_done <= 1'b1;
            o_frame_addr <= a;
            repeat (5) @(posedge i_mclk);
            o_frame_done <= 1'b0;
            o_frame_addr <= ~a;
        end
    endtask
    // Network attempt to change a port setting
    task send_cfg_write;
        begin
            o_cfg_write <= 1'b1;
            @(posedge i_mclk);
            o_cfg_write <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* tb/spcw_top_tb.sv */
// Self-checking bench for spcw_top with an AHB-Lite master.
// Assumes the network model drives the frame inputs.
`timescale 1ns/1ps
`default_nettype none
module spcw_top_tb;
    logic i_mclk = 1'b0, i_resetn = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
    logic [11:0] i_haddr = 12'h000;
    logic [1:0] i_htrans = 2'h0;
    logic [31:0] i_hwdata = 32'h0, o_hrdata, q;
    logic [15:0] i_stepped_freq = 16'h0000, o_baud_divisor, o_freq_setpoint;
    logic i_fault_clear_input = 1'b0, i_running = 1'b0, o_hreadyout, o_hresp, o_irq;
    logic i_frame_done, i_net_cfg_write, o_operator_port_owner, o_network_port_owner;
    logic o_two_stop_bits, o_frame_accept, o_reply_start, o_trip, irq_a;
    logic o_factory_debug_enable, o_decel_stop, o_coast_stop;
    logic [7:0] o_link_fault_trip_code;
    logic [5:0] i_frame_addr;
    logic [1:0] o_parity_select;
    int n_errors = 0, total_checks = 0;
    always #5 i_mclk = ~i_mclk;
    spcw_net_master net (.i_mclk(i_mclk), .o_frame_done(i_frame_done),
        .o_frame_addr(i_frame_addr), .o_cfg_write(i_net_cfg_write));
    spcw_top uut (.*, .i_hsize(3'h2), .i_hready(o_hreadyout));
    // Compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            total_checks++;
            if (g !== e) begin
                n_errors++;
                $display("BAD %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // One AHB single transfer
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        begin
            i_hsel <= 1'b1;
            i_haddr <= a;
            i_hwrite <= w;
            i_htrans <= 2'h2;
            t = 0;
            do begin @(posedge i_mclk); t++; end while (o_hreadyout !== 1'b1 && t < 50);
            i_htrans <= 2'h0;
            i_hwdata <= d;
            t = 0;
            do begin @(posedge i_mclk); t++; end while (o_hreadyout !== 1'b1 && t < 50);
            q = o_hrdata;
        end
    endtask
    task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
        begin
            ahb(1'b0, a, 32'h0);
            chk(nm, e, q);
        end
    endtask
    // -----------------------------------------
    // Scenarios
    // -----------------------------------------
    task s_reset;
        begin
            rd_chk("owner", 12'h000, 32'h2);
            rd_chk("baud", 12'h004, 32'h6);
            rd_chk("stop", 12'h010, 32'h1);
            rd_chk("action", 12'h014, 32'h2);
            rd_chk("debug", 12'h020, 32'h0);
            rd_chk("unmapped", 12'h100, 32'h0);
            chk("op_owner", 1, o_operator_port_owner);
            chk("dbg_out", 0, o_factory_debug_enable);
        end
    endtask
    task s_codes;
        logic [15:0] dv [3] = '{16'd20833, 16'd10416, 16'd5208};
        begin
            for (int i = 0; i < 3; i++) begin
                ahb(1'b1, 12'h004, 32'h4 + i);
                ahb(1'b1, 12'h00c, i);
                repeat (2) @(posedge i_mclk);
                chk("divisor", dv[i], o_baud_divisor);
                chk("parity", i, o_parity_select);
            end
            ahb(1'b1, 12'h004, 32'h7);
            rd_chk("baud_bad", 12'h004, 32'h6);
            ahb(1'b1, 12'h010, 32'h2);
            repeat (2) @(posedge i_mclk);
            chk("two_stop", 1, o_two_stop_bits);
            ahb(1'b1, 12'h020, 32'h1);
            repeat (2) @(posedge i_mclk);
            chk("dbg_on", 1, o_factory_debug_enable);
        end
    endtask
    task frame(input logic [5:0] a, input logic e);
        int t;
        begin
            fork net.send_frame(a); join_none
            t = 0;
            do begin @(posedge i_mclk); t++; end while (o_frame_accept !== 1'b1 && t < 12);
            chk("accept", e, o_frame_accept);
            if (e) chk("reply_now", 1, o_reply_start);
            repeat (8) @(posedge i_mclk);
        end
    endtask
    task s_network;
        begin
            ahb(1'b1, 12'h008, 32'h21);
            rd_chk("station_bad", 12'h008, 32'h1);
            ahb(1'b1, 12'h008, 32'h20);
            ahb(1'b1, 12'h000, 32'h3);
            repeat (2) @(posedge i_mclk);
            chk("net_owner", 1, o_network_port_owner);
            frame(6'h20, 1'b1);
            frame(6'h05, 1'b0);
            net.send_cfg_write;
            repeat (4) @(posedge i_mclk);
            rd_chk("baud_kept", 12'h004, 32'h6);
            rd_chk("irq_stat", 12'h030, 32'h8);
            ahb(1'b1, 12'h034, 32'h8);
            irq_a = o_irq;
            ahb(1'b1, 12'h034, 32'h0);
            chk("irq_mask", 1, irq_a ^ o_irq);
            ahb(1'b1, 12'h030, 32'h8);
            rd_chk("irq_clr", 12'h030, 32'h0);
            rd_chk("no_timeout", 12'h02c, 32'h0);
            chk("no_trip", 0, o_trip);
        end
    endtask
    task s_setpoint;
        begin
            i_stepped_freq <= 16'h0abc;
            ahb(1'b1, 12'h038, 32'h1234);
            repeat (2) @(posedge i_mclk);
            chk("default_f", 32'h1234, o_freq_setpoint);
            ahb(1'b1, 12'h024, 32'h1);
            repeat (2) @(posedge i_mclk);
            chk("kept_f", 32'h0abc, o_freq_setpoint);
        end
    endtask
    task give_verdict;
        begin
            $display("errors %0d checks %0d", n_errors, total_checks);
            if (n_errors == 0 && total_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Watchdog on the whole run
    initial begin
        #200000;
        n_errors++;
        give_verdict;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_mclk);
        s_reset;
        s_codes;
        s_network;
        s_setpoint;
        give_verdict;
    end
endmodule
`default_nettype wire
